//--- core/ncs_core.sv
// nibble core: paged sequencer, datapath, port latches, stop/wake and watchdog
`timescale 1ns/1ns
`include "ncs_cfg.svh"
module ncs_core
  import ncs_pkg::*;
#(
  parameter int WAKE_CYCLES = `NCS_WAKE_CYCLES,
  parameter int DOG_TICKS = `NCS_DOG_TICKS,
  parameter bit DOG_BY_CARRIER = 1'b1,
  parameter logic [3:0] WAKE_K_MASK = 4'hF,
  parameter logic [3:0] WAKE_R_MASK = 4'hF,
  parameter logic [3:0] PULLUP_R_MASK = 4'hF,
  parameter bit STOP_D_LOW = 1'b0
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [3:0] input_nibble_port,
  input wire logic [3:0] bidir_nibble_port_in,
  output logic [3:0] bidir_nibble_port_out,
  output logic [3:0] bidir_nibble_port_oe,
  output logic [3:0] bidir_pullup_en,
  output logic [9:0] open_drain_lines_oe,
  output logic carrier_out,
  output logic [2:0] carrier_mode
);

  generate
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535 || DOG_TICKS < 2 || DOG_TICKS > 65535)
    begin : g_bad_param
      $error("ncs_core: wake or watchdog count out of range");
    end
  endgenerate

  // open_drain_lines in bits 9:0, carrier in bit 10
  function automatic logic [10:0] line_sel(input logic hi, input logic [3:0] y);
    logic [10:0] s;
    s = 11'h000;
    if (hi)
    begin
      if (y == 4'h0)
        s[8] = 1'b1;
      else if (y == 4'h1)
        s[9] = 1'b1;
    end
    else if (y < 4'h8)
      s[y[2:0]] = 1'b1;
    else if (y == 4'h8)
      s[10] = 1'b1;
    return s;
  endfunction : line_sel

  function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
                                      input logic cin);
    return {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction : add4

  logic [3:0] k_meta_r;
  logic [3:0] k_s_r;
  logic [3:0] r_meta_r;
  logic [3:0] r_s_r;
  ncs_state_t state_r;
  logic [2:0] phase_r;
  logic [7:0] ir_r;
  logic [5:0] word_counter;
  logic [3:0] page_select_reg;
  logic [3:0] page_buffer_reg;
  logic [5:0] return_stack_word [2];
  logic [3:0] return_stack_page [2];
  logic [3:0] acc_r;
  logic [3:0] y_r;
  logic ram_page_bit;
  logic high_line_select_bit;
  logic flow_status_flag;
  logic [3:0] r_latch_r;
  logic [9:0] d_latch_r;
  logic carrier_lat_r;
  logic [2:0] carrier_mode_r;
  logic [7:0] prog_mem [1024];
  logic [3:0] data_mem [32];
  logic [15:0] wake_cnt_r;
  logic [15:0] dog_timer;
  logic soft_rst_r;
  logic run_r;
  logic [9:0] prog_addr_r;
  logic [31:0] prdata_r;
  logic err_r;
  logic exec;
  logic fetch;
  logic wake_low;
  logic stop_go;
  logic dog_kick;
  logic [10:0] sel;
  logic [3:0] mem_rd;
  logic [4:0] sum;
  logic [4:0] cmp;
  logic [4:0] imm_cmp;
  logic [4:0] acc_inc;

  assign exec = (state_r == NCS_RUN) && run_r && (phase_r == `NCS_PHASE_LAST); // RULE25
  assign fetch = (state_r == NCS_RUN) && run_r && (phase_r == 3'h0);
  assign mem_rd = data_mem[{ram_page_bit, y_r}]; // RULE10
  assign sel = line_sel(high_line_select_bit, y_r); // RULE11 RULE12
  assign wake_low = |((~k_s_r & WAKE_K_MASK) | (~r_s_r & WAKE_R_MASK)); // RULE17
  assign stop_go = exec && (ir_r == `NCS_OP_STOP) && !wake_low; // RULE24
  assign dog_kick = exec && ((ir_r == `NCS_OP_WDTR) ||
                    (DOG_BY_CARRIER && (ir_r == `NCS_OP_SO) && sel[10])); // RULE17
  assign cmp = add4(mem_rd, ~acc_r, 1'b1); // RULE13
  assign sum = add4(acc_r, mem_rd, 1'b0);
  assign imm_cmp = add4(ir_r[3:0], ~acc_r, 1'b1); // RULE13
  assign acc_inc = add4(acc_r, 4'h0, 1'b1);

  // pins cross into the clock domain through two flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      k_meta_r <= 4'hF;
      k_s_r <= 4'hF;
      r_meta_r <= 4'hF;
      r_s_r <= 4'hF;
    end
    else
    begin
      k_meta_r <= input_nibble_port;
      k_s_r <= k_meta_r;
      r_meta_r <= bidir_nibble_port_in;
      r_s_r <= r_meta_r;
    end
  end

  // machine phase, stop and wake sequencing
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= NCS_RUN;
      phase_r <= 3'h0;
      wake_cnt_r <= 16'h0000;
    end
    else if (soft_rst_r)
    begin
      state_r <= NCS_RUN;
      phase_r <= 3'h0;
      wake_cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        NCS_RUN:
        begin
          if (stop_go)
          begin
            state_r <= NCS_STOPPED; // RULE18
            phase_r <= 3'h0;
          end
          else if (!run_r || phase_r == `NCS_PHASE_LAST)
            phase_r <= 3'h0;
          else
            phase_r <= phase_r + 3'h1;
        end
        NCS_STOPPED:
        begin
          if (wake_low)
          begin
            state_r <= NCS_WARM; // RULE21
            wake_cnt_r <= 16'h0000;
          end
        end
        NCS_WARM:
        begin
          // sequencer idles here; the count runs on the restarted clock
          if (wake_cnt_r == 16'(WAKE_CYCLES - 1))
            state_r <= NCS_RUN; // RULE22 RULE26
          else
            wake_cnt_r <= wake_cnt_r + 16'h0001; // RULE26
        end
        default:
          state_r <= NCS_RUN;
      endcase
    end
  end

  // watchdog, ticks once per machine cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dog_timer <= 16'h0000;
      soft_rst_r <= 1'b0;
    end
    else
    begin
      soft_rst_r <= 1'b0;
      if (state_r != NCS_RUN || soft_rst_r)
        dog_timer <= 16'h0000; // RULE19 RULE23
      else if (dog_kick)
        dog_timer <= 16'h0000;
      else if (exec)
      begin
        if (dog_timer == 16'(DOG_TICKS - 1))
        begin
          dog_timer <= 16'h0000;
          soft_rst_r <= 1'b1;
        end
        else
          dog_timer <= dog_timer + 16'h0001;
      end
    end
  end

  // fetch in phase 0 loads the word that executes in the last phase of the same machine cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ir_r <= `NCS_OP_NOP;
    else if (soft_rst_r)
      ir_r <= `NCS_OP_NOP;
    else if (fetch)
      ir_r <= prog_mem[{page_select_reg, word_counter}]; // RULE1
  end

  // sequencer and datapath
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_counter <= `NCS_RST_WORD; // RULE7
      page_select_reg <= `NCS_RST_PAGE; // RULE7
      page_buffer_reg <= `NCS_RST_PAGE;
      return_stack_word[0] <= 6'h00;
      return_stack_word[1] <= 6'h00;
      return_stack_page[0] <= 4'h0;
      return_stack_page[1] <= 4'h0;
      acc_r <= 4'h0;
      y_r <= 4'h0;
      ram_page_bit <= 1'b0;
      high_line_select_bit <= 1'b0;
      flow_status_flag <= 1'b1;
      r_latch_r <= `NCS_RST_RLATCH; // RULE15
      d_latch_r <= `NCS_RST_DLATCH; // RULE15
      carrier_lat_r <= 1'b0; // RULE15
      carrier_mode_r <= 3'h0;
    end
    else if (soft_rst_r)
    begin
      word_counter <= `NCS_RST_WORD;
      page_select_reg <= `NCS_RST_PAGE;
      page_buffer_reg <= `NCS_RST_PAGE;
      flow_status_flag <= 1'b1;
      r_latch_r <= `NCS_RST_RLATCH;
      d_latch_r <= `NCS_RST_DLATCH;
      carrier_lat_r <= 1'b0;
    end
    else if (exec)
    begin
      word_counter <= word_counter + 6'h01; // RULE6 RULE2
      flow_status_flag <= 1'b1;
      case (ir_r[7:6])
        `NCS_GRP_JUMP:
        begin
          if (flow_status_flag) // RULE4
          begin
            page_select_reg <= page_buffer_reg; // RULE3
            word_counter <= ir_r[5:0]; // RULE8
          end
        end
        `NCS_GRP_CAL:
        begin
          if (flow_status_flag) // RULE4
          begin
            // a third nested call drops the oldest entry
            return_stack_word[1] <= return_stack_word[0]; // RULE9
            return_stack_page[1] <= return_stack_page[0];
            return_stack_word[0] <= word_counter + 6'h01;
            return_stack_page[0] <= page_select_reg;
            page_select_reg <= page_buffer_reg; // RULE3
            word_counter <= ir_r[5:0]; // RULE8
          end
        end
        default:
        begin
          case (ir_r[7:4])
            `NCS_NIB_LDPB: page_buffer_reg <= ir_r[3:0]; // RULE3
            `NCS_NIB_LYI: y_r <= ir_r[3:0];
            `NCS_NIB_YNEI: flow_status_flag <= (y_r != ir_r[3:0]); // RULE14
            `NCS_NIB_ALEI: flow_status_flag <= imm_cmp[4]; // RULE13
            `NCS_NIB_BIT:
            begin
              case (ir_r[3:2])
                `NCS_BIT_LXI: {high_line_select_bit, ram_page_bit} <= ir_r[1:0];
                `NCS_BIT_SEM: data_mem[{ram_page_bit, y_r}][ir_r[1:0]] <= 1'b1;
                `NCS_BIT_REM: data_mem[{ram_page_bit, y_r}][ir_r[1:0]] <= 1'b0;
                default: flow_status_flag <= mem_rd[ir_r[1:0]];
              endcase
            end
            default:
            begin
              case (ir_r)
                `NCS_OP_LAY: acc_r <= y_r;
                `NCS_OP_LYA: y_r <= acc_r;
                `NCS_OP_LAZ: acc_r <= 4'h0;
                `NCS_OP_LMA: data_mem[{ram_page_bit, y_r}] <= acc_r; // RULE10
                `NCS_OP_LYM: y_r <= mem_rd;
                `NCS_OP_LAM: acc_r <= mem_rd;
                `NCS_OP_XMA:
                begin
                  acc_r <= mem_rd;
                  data_mem[{ram_page_bit, y_r}] <= acc_r;
                end
                `NCS_OP_AM: {flow_status_flag, acc_r} <= sum; // RULE14
                `NCS_OP_SM: {flow_status_flag, acc_r} <= cmp; // RULE13 RULE14
                `NCS_OP_IM: {flow_status_flag, acc_r} <= add4(mem_rd, 4'h0, 1'b1);
                `NCS_OP_DM: {flow_status_flag, acc_r} <= add4(mem_rd, 4'hF, 1'b0);
                `NCS_OP_IA: acc_r <= acc_inc[3:0];
                `NCS_OP_IY: {flow_status_flag, y_r} <= add4(y_r, 4'h0, 1'b1);
                `NCS_OP_DA: {flow_status_flag, acc_r} <= add4(acc_r, 4'hF, 1'b0);
                `NCS_OP_DY: {flow_status_flag, y_r} <= add4(y_r, 4'hF, 1'b0);
                `NCS_OP_EORM: acc_r <= acc_r ^ mem_rd;
                `NCS_OP_NEGA: {flow_status_flag, acc_r} <= add4(~acc_r, 4'h0, 1'b1);
                `NCS_OP_ALEM: flow_status_flag <= cmp[4];
                `NCS_OP_MNEZ: flow_status_flag <= (mem_rd != 4'h0);
                `NCS_OP_YNEA: flow_status_flag <= (y_r != acc_r); // RULE14
                `NCS_OP_KNEZ: flow_status_flag <= (k_s_r != 4'h0);
                `NCS_OP_RNEZ: flow_status_flag <= (r_s_r != 4'h0); // RULE16
                `NCS_OP_LAK: acc_r <= k_s_r;
                `NCS_OP_LAR: acc_r <= r_s_r; // RULE16
                `NCS_OP_SO:
                begin
                  d_latch_r <= d_latch_r | sel[9:0]; // RULE11
                  carrier_lat_r <= carrier_lat_r | sel[10];
                end
                `NCS_OP_RO:
                begin
                  d_latch_r <= d_latch_r & ~sel[9:0]; // RULE11
                  carrier_lat_r <= carrier_lat_r & ~sel[10];
                end
                `NCS_OP_RET:
                begin
                  word_counter <= return_stack_word[0]; // RULE8
                  page_select_reg <= return_stack_page[0]; // RULE5
                  return_stack_word[0] <= return_stack_word[1];
                  return_stack_page[0] <= return_stack_page[1];
                end
                `NCS_OP_LRA: r_latch_r <= acc_r;
                `NCS_OP_LPMR: carrier_mode_r <= y_r[2:0]; // RULE12
                default: flow_status_flag <= 1'b1;
              endcase
            end
          endcase
        end
      endcase
    end
  end

  // pin drivers; latches stay intact through stop so wake restores them
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      open_drain_lines_oe <= 10'h3FF; // RULE15
      carrier_out <= 1'b0; // RULE15
      bidir_nibble_port_oe <= 4'h0; // RULE15
    end
    else
    begin
      bidir_nibble_port_oe <= ~r_latch_r; // RULE16
      if (state_r == NCS_STOPPED)
      begin
        open_drain_lines_oe[9:8] <= 2'h3; // RULE19
        open_drain_lines_oe[7:0] <= STOP_D_LOW ? 8'hFF : ~d_latch_r[7:0]; // RULE20
        carrier_out <= 1'b0; // RULE19
      end
      else
      begin
        open_drain_lines_oe <= ~d_latch_r; // RULE21
        carrier_out <= carrier_lat_r; // RULE21
      end
    end
  end

  assign bidir_nibble_port_out = 4'h0;
  assign bidir_pullup_en = PULLUP_R_MASK; // RULE17
  assign carrier_mode = carrier_mode_r;

  // apb: zero wait states, read data captured in the setup cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_r <= `NCS_RST_RUN;
      prog_addr_r <= 10'h000;
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      err_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      case (paddr)
        `NCS_OFS_CTRL: prdata_r[0] <= run_r;
        `NCS_OFS_STATUS:
        begin
          prdata_r[5:0] <= word_counter;
          prdata_r[11:8] <= page_select_reg;
          prdata_r[`NCS_STATUS_FLAG_BIT] <= flow_status_flag;
          prdata_r[`NCS_STATUS_STATE_LSB +: 2] <= state_r;
        end
        `NCS_OFS_REGS:
          prdata_r[14:0] <= {carrier_mode_r, 2'h0, high_line_select_bit, ram_page_bit,
                             y_r, acc_r};
        `NCS_OFS_PADDR: prdata_r[9:0] <= prog_addr_r;
        `NCS_OFS_PDATA: prdata_r[7:0] <= prog_mem[prog_addr_r];
        default: err_r <= 1'b1;
      endcase
    end
    else if (psel && penable && pwrite)
    begin
      case (paddr)
        `NCS_OFS_CTRL: run_r <= pwdata[0];
        `NCS_OFS_PADDR: prog_addr_r <= pwdata[9:0];
        `NCS_OFS_PDATA:
        begin
          prog_mem[prog_addr_r] <= pwdata[7:0];
          prog_addr_r <= prog_addr_r + 10'h001;
        end
        default: err_r <= err_r;
      endcase
    end
  end

  assign pready = psel && penable;
  assign pslverr = pready && err_r;
  assign prdata = prdata_r;

endmodule : ncs_core

//--- include/ncs_cfg.svh
// constants for the nibble core sequencer: offsets, reset values, opcodes, timing
// Behaviour
// [RULE1] Program memory is sixty-four byte pages; word counter low bits, page register high.
// [RULE2] Page register picks one of sixteen pages and holds during sequential flow.
// [RULE3] Load-page-buffer stores operand; buffer moves to page only on taken jump/call.
// [RULE4] Jump and call transfer only when status flag is one.
// [RULE5] Return restores the saved page together with the saved word address.
// [RULE6] Word counter advances every instruction to the next word in the page.
// [RULE7] Reset clears word counter and page register, starting at page zero word zero.
// [RULE8] Jump/call load six operand bits; return loads word from the stack top.
// [RULE9] Return stack has two entries of word address and page number.
// [RULE10] Data memory is 32 nibbles, page from page-pointer bit zero, word from index.
// [RULE11] Upper page-pointer bit selects lines eight and nine for index zero and one.
// [RULE12] Index register addresses data, selects output bit and carrier mode.
// [RULE13] Four-bit adder subtracts by adding inverted accumulator plus one.
// [RULE14] Designated instructions set status flag on overflow or unequal compare.
// [RULE15] Reset drives all ten lines and carrier low, bidirectional port released high.
// [RULE16] Bidirectional bit is an input only while the device releases it high.
// [RULE17] Mask options: carrier kicks watchdog, wake-up bits, bidirectional pull-ups.
// [RULE18] Stop instruction halts clocking and instruction execution.
// [RULE19] In stop, watchdog held cleared, lines eight, nine and carrier forced low.
// [RULE20] Lines zero to seven in stop are low or kept, by mask option.
// [RULE21] Any enabled wake bit low ends stop; lines and carrier return to previous.
// [RULE22] After wake-up wait 1024 times 8 clocks before the first instruction.
// [RULE23] Watchdog restarts counting from zero after stop.
// [RULE24] Stop with an enabled wake bit already low acts as no-operation.
// [RULE25] One instruction per machine cycle of six clocks, fetch overlapped; the core fetches in phase 0 of the cycle that executes the word.
// [RULE26] Dedicated counter times wake delay and holds the sequencer idle meanwhile.
`ifndef NCS_CFG_SVH
`define NCS_CFG_SVH
`define NCS_OFS_CTRL 12'h000
`define NCS_OFS_STATUS 12'h004
`define NCS_OFS_REGS 12'h008
`define NCS_OFS_PADDR 12'h00C
`define NCS_OFS_PDATA 12'h010
`define NCS_RST_RUN 1'b0
`define NCS_RST_PAGE 4'h0
`define NCS_RST_WORD 6'h00
`define NCS_RST_RLATCH 4'hF
`define NCS_RST_DLATCH 10'h000
`define NCS_STATUS_FLAG_BIT 12
`define NCS_STATUS_STATE_LSB 16
`define NCS_MACHINE_CLOCKS 6
`define NCS_PHASE_LAST 3'h5
`define NCS_WAKE_CYCLES (1024 * 8)
`define NCS_DOG_TICKS 8192
`define NCS_GRP_JUMP 2'h3
`define NCS_GRP_CAL 2'h2
`define NCS_NIB_LDPB 4'h7
`define NCS_NIB_LYI 4'h6
`define NCS_NIB_YNEI 4'h5
`define NCS_NIB_ALEI 4'h4
`define NCS_NIB_BIT 4'h3
`define NCS_BIT_LXI 2'h0
`define NCS_BIT_SEM 2'h1
`define NCS_BIT_REM 2'h2
`define NCS_BIT_TM 2'h3
`define NCS_OP_NOP 8'h00
`define NCS_OP_LAY 8'h01
`define NCS_OP_LYA 8'h02
`define NCS_OP_LAZ 8'h03
`define NCS_OP_LMA 8'h04
`define NCS_OP_LYM 8'h05
`define NCS_OP_LAM 8'h06
`define NCS_OP_XMA 8'h07
`define NCS_OP_AM 8'h08
`define NCS_OP_SM 8'h09
`define NCS_OP_IM 8'h0A
`define NCS_OP_DM 8'h0B
`define NCS_OP_IA 8'h0C
`define NCS_OP_IY 8'h0D
`define NCS_OP_DA 8'h0E
`define NCS_OP_DY 8'h0F
`define NCS_OP_EORM 8'h10
`define NCS_OP_NEGA 8'h11
`define NCS_OP_ALEM 8'h12
`define NCS_OP_MNEZ 8'h13
`define NCS_OP_YNEA 8'h14
`define NCS_OP_KNEZ 8'h15
`define NCS_OP_RNEZ 8'h16
`define NCS_OP_LAK 8'h17
`define NCS_OP_LAR 8'h18
`define NCS_OP_SO 8'h19
`define NCS_OP_RO 8'h1A
`define NCS_OP_RET 8'h1B
`define NCS_OP_STOP 8'h1C
`define NCS_OP_WDTR 8'h1D
`define NCS_OP_LRA 8'h1E
`define NCS_OP_LPMR 8'h1F
`endif

//--- include/ncs_pkg.sv
// types for the nibble core sequencer
package ncs_pkg;
  typedef enum logic [1:0] {
    NCS_RUN = 2'b00,
    NCS_STOPPED = 2'b01,
    NCS_WARM = 2'b10
  } ncs_state_t;
endpackage : ncs_pkg

//--- tb/ncs_core_checker.sv
// port-level assertions for the nibble core
`timescale 1ns/1ns
`include "ncs_cfg.svh"
module ncs_core_checker #(
  parameter logic [3:0] PULLUP_R_MASK = 4'hF
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [3:0] bidir_nibble_port_out,
  input wire logic [3:0] bidir_nibble_port_oe,
  input wire logic [3:0] bidir_pullup_en,
  input wire logic [9:0] open_drain_lines_oe,
  input wire logic carrier_out
);
  logic run_seen_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // status reads before the first run request must show the reset address
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      run_seen_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == `NCS_OFS_CTRL && pwdata[0])
      run_seen_r <= 1'b1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_status_rd;
    s_access ##0 (!pwrite && paddr == `NCS_OFS_STATUS);
  endsequence
  AST_RESET_PINS: assert property (
    $rose(rst_b) |-> open_drain_lines_oe == 10'h3FF && !carrier_out
      && bidir_nibble_port_oe == 4'h0) else $error("pins not at reset levels");
  AST_RESET_ADDR: assert property (
    s_status_rd ##0 !run_seen_r |-> prdata[11:0] == 12'h000)
    else $error("address not zero after reset");
  AST_STOP_FORCE: assert property (
    s_status_rd ##0 (prdata[17:16] == 2'h1) |-> open_drain_lines_oe[9:8] == 2'b11
      && !carrier_out) else $error("stopped but lines or carrier not low");
  AST_BIDIR_OPEN: assert property (
    bidir_nibble_port_out == 4'h0) else $error("bidir port drives high");
  AST_PULLUP_OPT: assert property (
    bidir_pullup_en == PULLUP_R_MASK) else $error("pull-up option mismatch");
  AST_ZERO_WAIT: assert property (
    s_setup ##1 s_access |-> pready) else $error("access not answered at once");
  AST_PRDATA_HOLD: assert property (
    s_access ##1 !psel |-> $stable(prdata)) else $error("read data changed when idle");
  AST_ERR_IN_ACCESS: assert property (
    pslverr |-> s_access) else $error("error outside access phase");
endmodule : ncs_core_checker

bind ncs_core ncs_core_checker #(.PULLUP_R_MASK(PULLUP_R_MASK)) ncs_core_checker_i (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bidir_nibble_port_out(bidir_nibble_port_out), .bidir_nibble_port_oe(bidir_nibble_port_oe),
  .bidir_pullup_en(bidir_pullup_en), .open_drain_lines_oe(open_drain_lines_oe),
  .carrier_out(carrier_out));

//--- tb/ncs_pin_model.sv
// pin-side model: key switches and open-drain bidir bits with pull-ups
`timescale 1ns/1ns
module ncs_pin_model (
  // clock
  input wire logic clock,
  // from the core
  input wire logic [3:0] bidir_nibble_port_oe,
  input wire logic [3:0] bidir_nibble_port_out,
  input wire logic [3:0] bidir_pullup_en,
  // switch settings
  input wire logic [3:0] key_sw,
  input wire logic [3:0] bidir_sw,
  // pin levels
  output logic [3:0] input_nibble_port,
  output logic [3:0] bidir_nibble_port_in
);
  logic [3:0] float_r = 4'h5;
  // an unpulled released bit must not settle to a friendly value
  always_ff @(posedge clock)
    float_r <= ~float_r;
  assign input_nibble_port = key_sw;
  always_comb
    for (int i = 0; i < 4; i++)
      bidir_nibble_port_in[i] = (bidir_nibble_port_oe[i] && !bidir_nibble_port_out[i])
        ? 1'b0 : !bidir_sw[i] ? 1'b0 : bidir_pullup_en[i] ? 1'b1 : float_r[i];
endmodule : ncs_pin_model

//--- tb/ncs_core_bench.sv
// self-checking bench: program load over apb, paging, calls, stop and wake
`timescale 1ns/1ns
`include "ncs_cfg.svh"
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module ncs_core_bench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] key_sw = 4'hE;
  logic [3:0] bidir_sw = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] input_nibble_port, bidir_nibble_port_in, bidir_nibble_port_out;
  logic [3:0] bidir_nibble_port_oe, bidir_pullup_en;
  logic [9:0] open_drain_lines_oe;
  logic carrier_out;
  logic [2:0] carrier_mode;
  int mismatches = 0;
  int n_compared = 0;
  // page 0: index load, buffer load, equal compare, untaken jump, call, carrier, stop loop
  logic [7:0] pg0 [11] = '{8'h60, 8'h72, 8'h50, 8'hF0, 8'h63, 8'h85, 8'h30, 8'h68,
    `NCS_OP_SO, `NCS_OP_STOP, 8'hC9};
  // page 2: lines 3 and 9, carrier mode 1, buffer back to page 0 so the loop jump stays home
  logic [7:0] pg2 [7] = '{`NCS_OP_SO, 8'h32, 8'h61, `NCS_OP_SO, `NCS_OP_LPMR, 8'h70,
    `NCS_OP_RET};

  always #20 clock = ~clock;

  // watchdog stays far above run length so it never resets the core here
  ncs_core #(.WAKE_CYCLES(16), .DOG_TICKS(4096)) ncs_core_i (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_nibble_port(input_nibble_port), .bidir_nibble_port_in(bidir_nibble_port_in),
    .bidir_nibble_port_out(bidir_nibble_port_out),
    .bidir_nibble_port_oe(bidir_nibble_port_oe), .bidir_pullup_en(bidir_pullup_en),
    .open_drain_lines_oe(open_drain_lines_oe), .carrier_out(carrier_out),
    .carrier_mode(carrier_mode));
  ncs_pin_model ncs_pin_model_i (
    .clock(clock), .bidir_nibble_port_oe(bidir_nibble_port_oe),
    .bidir_nibble_port_out(bidir_nibble_port_out), .bidir_pullup_en(bidir_pullup_en),
    .key_sw(key_sw), .bidir_sw(bidir_sw), .input_nibble_port(input_nibble_port),
    .bidir_nibble_port_in(bidir_nibble_port_in));

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // one apb transfer, entered just after a rising edge; one idle edge afterwards
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic poll(input logic [17:0] m, input logic [17:0] v, output logic [31:0] q);
    int n;
    logic e;
    n = 0;
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    while ((q[17:0] & m) !== v && n < 300)
    begin
      n++;
      apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    end
  endtask : poll

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    logic [31:0] q;
    logic [31:0] r;
    logic e;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    `CHK(open_drain_lines_oe, 10'h3FF);
    `CHK(carrier_out, 1'b0);
    `CHK(bidir_nibble_port_oe, 4'h0);
    apb(1'b1, `NCS_OFS_STATUS, 32'hFFFF_FFFF, q, e);
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    `CHK(q, 32'h0000_1000);
    apb(1'b0, 12'h014, 32'h0, q, e);
    `CHK(e, 1'b1);
    apb(1'b1, `NCS_OFS_PADDR, 32'h0, q, e);
    foreach (pg0[i]) apb(1'b1, `NCS_OFS_PDATA, {24'h0, pg0[i]}, q, e);
    apb(1'b1, `NCS_OFS_PADDR, 32'h85, q, e);
    foreach (pg2[i]) apb(1'b1, `NCS_OFS_PDATA, {24'h0, pg2[i]}, q, e);
    apb(1'b1, `NCS_OFS_PADDR, 32'h0, q, e);
    apb(1'b0, `NCS_OFS_PDATA, 32'h0, q, e);
    `CHK(q, 32'h60);
    apb(1'b1, `NCS_OFS_CTRL, 32'h1, q, e);
    apb(1'b0, `NCS_OFS_CTRL, 32'h0, q, e);
    `CHK(q, 32'h1);
    // wake key held low: stop acts as no-op, loop stays on page 0 words 9 and 10
    poll(18'h30F3C, 18'h00008, q);
    `CHK(q[17:0] & 18'h30F3C, 18'h00008);
    // word 8 also matches, just before the carrier set runs
    repeat (8) @(posedge clock);
    `CHK(open_drain_lines_oe, 10'h1F7);
    `CHK(carrier_out, 1'b1);
    apb(1'b0, `NCS_OFS_REGS, 32'h0, q, e);
    `CHK(q[9:4], 6'h08);
    `CHK(q[14:12], 3'h1);
    `CHK(carrier_mode, 3'h1);
    key_sw <= 4'hF;
    poll(18'h30000, 18'h10000, q);
    `CHK(q[17:16], 2'h1);
    `CHK(open_drain_lines_oe, 10'h3F7);
    `CHK(carrier_out, 1'b0);
    repeat (40) @(posedge clock);
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, r, e);
    `CHK(r, q);
    `CHK(open_drain_lines_oe[7:0], 8'hF7);
    key_sw <= 4'hE;
    repeat (5) @(posedge clock);
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    `CHK(q[17:16], 2'h2);
    `CHK(open_drain_lines_oe, 10'h1F7);
    `CHK(carrier_out, 1'b1);
    repeat (20) @(posedge clock);
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    `CHK(q[17:16], 2'h0);
    repeat (24) @(posedge clock);
    apb(1'b0, `NCS_OFS_STATUS, 32'h0, q, e);
    `CHK(q[17:0] & 18'h30F3C, 18'h00008);
    results();
  end
endmodule : ncs_core_bench
